// [src/pdcs_regs.vh]
`ifndef PDCS_REGS_VH
`define PDCS_REGS_VH

`define PDCS_ADDR_W          8
`define PDCS_OFS_DEV_CTL_STS 8'hE8

`define PDCS_BIT_CORR_EN     0
`define PDCS_BIT_NFAT_EN     1
`define PDCS_BIT_FAT_EN      2
`define PDCS_BIT_UR_EN       3
`define PDCS_BIT_RLX_ORD     4
`define PDCS_MPS_LSB         5
`define PDCS_MPS_MSB         7
`define PDCS_BIT_AUX_PM_EN   10
`define PDCS_STS_LSB         16
`define PDCS_BIT_CORR_DET    16
`define PDCS_BIT_NFAT_DET    17
`define PDCS_BIT_FAT_DET     18
`define PDCS_BIT_UR_DET      19
`define PDCS_BIT_AUX_DET     20

`define PDCS_RST_ERR_EN      4'h0
`define PDCS_RST_RLX_ORD     1'h1
`define PDCS_RST_MPS         3'h0
`define PDCS_RST_AUX_PM_EN   1'h0
`define PDCS_RST_ERR_DET     4'h0
`define PDCS_RST_AUX_DET     1'h1
`define PDCS_MPS_SUPPORTED   3'h1

`endif

// [src/pdcs_err_flag.v]
`timescale 1ns/100ps
`default_nettype none

module pdcs_err_flag
(
	input  wire clk_sys,
	input  wire rst_n,
	input  wire detect,
	input  wire clear,
	input  wire report_en,
	output reg  flag,
	output reg  msg
);

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flag <= 1'b0;
			msg  <= 1'b0;
		end
		else
		begin
			// Set beats a simultaneous clear, so no event is lost
			if (detect)
				flag <= 1'b1;
			else if (clear)
				flag <= 1'b0;
			msg <= detect & report_en;
		end
	end

endmodule // pdcs_err_flag

`default_nettype wire

// [src/pdcs_dev_ctl_sts.v]
`timescale 1ns/100ps
`default_nettype none
`include "pdcs_regs.vh"

module pdcs_dev_ctl_sts
(
	input  wire                    clk_sys,
	input  wire                    rst_n,
	input  wire [`PDCS_ADDR_W-1:0] reg_addr,
	input  wire [31:0]             reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [31:0]             reg_rdata,
	input  wire                    dflt_load,
	input  wire [15:0]             dflt_value,
	input  wire                    err_corr,
	input  wire                    err_nonfatal,
	input  wire                    err_fatal,
	input  wire                    err_unsupported,
	input  wire                    aux_power_pin,
	output reg  [3:0]              report_en,
	output reg                     relaxed_order_en,
	output reg  [2:0]              payload_limit,
	output reg                     aux_pm_en,
	output wire [3:0]              err_detected,
	output wire [3:0]              err_msg,
	output reg                     aux_power_present
);

	reg        aux_s1;
	reg        aux_s2;
	reg        aux_s3;
	reg [2:0]  next_payload_limit;
	reg [2:0]  dflt_payload;
	reg [15:0] ctl_view;
	reg [31:0] next_rdata;
	wire       hit;
	wire       ctl_wr;
	wire [3:0] clr;
	wire [3:0] det;

	assign hit    = (reg_addr == `PDCS_OFS_DEV_CTL_STS);
	assign ctl_wr = reg_wr & hit;
	assign det    = {err_unsupported, err_fatal, err_nonfatal, err_corr};
	assign clr    = ctl_wr ? reg_wdata[`PDCS_BIT_UR_DET:`PDCS_BIT_CORR_DET] : 4'h0;

	// Clamp on both software writes and default loads
	always @*
	begin
		next_payload_limit = reg_wdata[`PDCS_MPS_MSB:`PDCS_MPS_LSB];
		if (next_payload_limit > `PDCS_MPS_SUPPORTED)
			next_payload_limit = `PDCS_MPS_SUPPORTED;
		dflt_payload = dflt_value[`PDCS_MPS_MSB:`PDCS_MPS_LSB];
		if (dflt_payload > `PDCS_MPS_SUPPORTED)
			dflt_payload = `PDCS_MPS_SUPPORTED;
	end

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			report_en        <= `PDCS_RST_ERR_EN;
			relaxed_order_en <= `PDCS_RST_RLX_ORD;
			payload_limit    <= `PDCS_RST_MPS;
			aux_pm_en        <= `PDCS_RST_AUX_PM_EN;
		end
		else if (ctl_wr)
		begin
			// Software write wins over a default load in the same cycle
			report_en        <= reg_wdata[`PDCS_BIT_UR_EN:`PDCS_BIT_CORR_EN];
			relaxed_order_en <= reg_wdata[`PDCS_BIT_RLX_ORD];
			payload_limit    <= next_payload_limit;
		end
		else if (dflt_load)
		begin
			report_en        <= dflt_value[`PDCS_BIT_UR_EN:`PDCS_BIT_CORR_EN];
			relaxed_order_en <= dflt_value[`PDCS_BIT_RLX_ORD];
			payload_limit    <= dflt_payload;
			aux_pm_en        <= dflt_value[`PDCS_BIT_AUX_PM_EN];
		end
	end

	// Pin sync; second and third stages must agree before a change counts
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aux_s1            <= `PDCS_RST_AUX_DET;
			aux_s2            <= `PDCS_RST_AUX_DET;
			aux_s3            <= `PDCS_RST_AUX_DET;
			aux_power_present <= `PDCS_RST_AUX_DET;
		end
		else
		begin
			aux_s1 <= aux_power_pin;
			aux_s2 <= aux_s1;
			aux_s3 <= aux_s2;
			if (aux_s2 == aux_s3)
				aux_power_present <= aux_s3;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : gen_flag
			pdcs_err_flag u_flag
			(
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.detect    (det[g]),
				.clear     (clr[g]),
				.report_en (report_en[g]),
				.flag      (err_detected[g]),
				.msg       (err_msg[g])
			);
		end
	endgenerate

	always @*
	begin
		ctl_view = 16'h0000;
		ctl_view[`PDCS_BIT_UR_EN:`PDCS_BIT_CORR_EN] = report_en;
		ctl_view[`PDCS_BIT_RLX_ORD] = relaxed_order_en;
		ctl_view[`PDCS_MPS_MSB:`PDCS_MPS_LSB] = payload_limit;
		ctl_view[`PDCS_BIT_AUX_PM_EN] = aux_pm_en;
		next_rdata = 32'h0000_0000;
		// Unmapped addresses read zero
		if (hit)
		begin
			next_rdata[15:0] = ctl_view;
			next_rdata[`PDCS_BIT_UR_DET:`PDCS_BIT_CORR_DET] = err_detected;
			next_rdata[`PDCS_BIT_AUX_DET] = aux_power_present;
		end
	end

	// Read data valid only in the cycle after the strobe
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 32'h0000_0000;
	end

endmodule // pdcs_dev_ctl_sts

`default_nettype wire

// [test/pdcs_err_src.sv]
`timescale 1ns/100ps
`default_nettype none
module pdcs_err_src
(
	input  wire logic       clk_sys,
	input  wire logic       go,
	input  wire logic [3:0] which,
	output var  logic [3:0] err
);
	// One detect pulse per request
	always_ff @(posedge clk_sys)
		err <= go ? which : 4'h0;
endmodule // pdcs_err_src
`default_nettype wire

// [test/pdcs_chk_props.sv]
`timescale 1ns/100ps
`default_nettype none
module pdcs_chk
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        err_corr,
	input wire logic        err_fatal,
	input wire logic [3:0]  report_en,
	input wire logic [2:0]  payload_limit,
	input wire logic [3:0]  err_detected,
	input wire logic [3:0]  err_msg
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_rd; reg_rd && reg_addr == 8'hE8; endsequence
	property p_en; s_rd |=> reg_rdata[3:0] == $past(report_en); endproperty
	property p_pl; s_rd |=> reg_rdata[7:5] == $past(payload_limit); endproperty
	property p_ro; s_rd |=> reg_rdata[31:21] == 11'h0 && reg_rdata[15:11] == 5'h0; endproperty
	property p_max; payload_limit <= 3'h1; endproperty
	property p_det; err_corr |=> err_detected[0]; endproperty
	property p_msg; err_fatal |=> err_msg[2] == $past(report_en[2]); endproperty
	property p_w1c; reg_wr && reg_addr == 8'hE8 && reg_wdata[18] && !err_fatal |=> !err_detected[2];
	endproperty
	property p_zero; !(reg_rd && reg_addr == 8'hE8) |=> reg_rdata == 32'h0; endproperty
	a_en: assert property (p_en) else $error("enable readback");
	a_pl: assert property (p_pl) else $error("payload readback");
	a_ro: assert property (p_ro) else $error("zero bits set");
	a_max: assert property (p_max) else $error("payload above max");
	a_det: assert property (p_det) else $error("flag not set");
	a_msg: assert property (p_msg) else $error("message wrong");
	a_w1c: assert property (p_w1c) else $error("flag not cleared");
	a_zero: assert property (p_zero) else $error("idle read data");
endmodule // pdcs_chk
bind pdcs_dev_ctl_sts pdcs_chk i_pdcs_chk (.*);
`default_nettype wire

// [test/test_pdcs_dev_ctl_sts.sv]
`timescale 1ns/100ps
`default_nettype none
module test_pdcs_dev_ctl_sts;
	logic clk_sys, rst_n, reg_wr, reg_rd, dflt_load, aux_pin, go;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] dflt_value;
	logic [3:0] which, err, err_msg;
	int n_fail = 0;
	int n_checks = 0;
	pdcs_err_src i_pdcs_err_src (.clk_sys(clk_sys), .go(go), .which(which), .err(err));
	pdcs_dev_ctl_sts i_pdcs_dev_ctl_sts (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.dflt_load(dflt_load), .dflt_value(dflt_value), .err_corr(err[0]), .err_nonfatal(err[1]),
		.err_fatal(err[2]), .err_unsupported(err[3]), .aux_power_pin(aux_pin), .report_en(),
		.relaxed_order_en(), .payload_limit(), .aux_pm_en(), .err_detected(), .err_msg(err_msg),
		.aux_power_present());
	task automatic wr(input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= 8'hE8;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		n_checks++;
		if (reg_rdata !== e)
		begin
			n_fail++;
			$display("FAIL %0t read %h want %h", $time, reg_rdata, e);
		end
	endtask
	// Message pulse stands one cycle after the detect edge
	task automatic fire(input logic [3:0] w, input logic [3:0] e);
		@(posedge clk_sys);
		go <= 1'b1;
		which <= w;
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		#1;
		n_checks++;
		if (err_msg !== e)
		begin
			n_fail++;
			$display("FAIL %0t message %h want %h", $time, err_msg, e);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Whole run needs about 50 cycles
	initial
	begin
		#20000;
		n_fail++;
		finish_test;
	end
	initial
	begin
		{rst_n, reg_wr, reg_rd, dflt_load, go, which, reg_addr, reg_wdata, dflt_value} = '0;
		aux_pin = 1'b1;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(8'hE8, 32'h0010_0010);
		$display("test reset done");
		wr(32'h0000_FFFF);
		rd(8'hE8, 32'h0010_003F);
		fire(4'hF, 4'hF);
		wr(32'h000F_0000);
		fire(4'hF, 4'h0);
		rd(8'hE8, 32'h001F_0000);
		wr(32'h000A_0000);
		rd(8'hE8, 32'h0015_0000);
		$display("test errors done");
		@(posedge clk_sys);
		dflt_load <= 1'b1;
		dflt_value <= 16'h04FF;
		@(posedge clk_sys);
		dflt_load <= 1'b0;
		rd(8'hE8, 32'h0015_043F);
		wr(32'h0000_0000);
		rd(8'hE8, 32'h0015_0400);
		rd(8'hEC, 32'h0000_0000);
		@(posedge clk_sys);
		aux_pin <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rd(8'hE8, 32'h0005_0400);
		$display("test defaults done");
		finish_test;
	end
endmodule // test_pdcs_dev_ctl_sts
`default_nettype wire
